/* File: ddc_edid_cp_slave_port.sv */
// Purpose: Slave port answering the identification table and the
//          content-protection register map on the display data port
// Assumes: The serial clock is the link clock; SDA is open drain
// Notes:   Contract
// Contract
// - Answer address a0, identification table read-only
// - Answer address 74, protection registers read/write
// - Standard subaddressed write and read sequences
// - Counter keeps last location for current reads
// - Counter steps by one per access
// - Current-address read served from counter
// - Short read format on protection map
// - Auto-increment over successive data bytes
// - Invalid subaddress: no acknowledge, back idle
// - Past top, keep returning top byte
// - Out-of-sequence start restarts the address phase, stop forces idle
`default_nettype none

module ddc_edid_cp_slave_port #(
    parameter logic [7:0] EDID_TOP = ddc_pkg::EDID_TOP_DEF,
    parameter logic [7:0] CP_TOP   = ddc_pkg::CP_TOP_DEF
) (
    input  wire logic            CLK,
    input  wire logic            RESET_N,
    input  wire logic            PORT_A_DDC_SERIAL_CLOCK,
    input  wire logic            PORT_A_DDC_SERIAL_DATA_IN,
    output logic                 PORT_A_DDC_SERIAL_DATA_OUT,
    output logic                 PORT_A_DDC_SERIAL_DATA_OE_N,
    input  wire logic            TABLE_WR_EN,
    input  wire logic [7:0]      TABLE_WR_ADDR,
    input  wire logic [7:0]      TABLE_WR_DATA,
    input  wire logic [7:0]      CP_RD_ADDR,
    output logic [7:0]           CP_RD_DATA,
    output logic                 CP_WR_STROBE,
    output ddc_pkg::cp_wr_t      CP_WR
);

    // Storage: table written by system, registers written by link
    logic [7:0] display_identification_table [0:255];
    logic [7:0] cp_mem [0:255];

    // Link domain state
    ddc_pkg::link_state_t state_r, state_nxt; // Transfer phase
    logic [2:0]      bit_cnt_r;     // Bit within byte
    logic [6:0]      shift_r;       // Received bits so far
    logic            sda_pos_r;     // SDA sampled at rising edge
    logic            rst_meta_r;    // Reset sync, first stage
    logic            link_rst_n;    // Reset sync, second stage
    logic            sel_cp_r;      // Protection map selected
    logic            rw_r;          // Master reads
    logic            over_r;        // Counter passed top
    logic [7:0]      edid_cnt_r;    // Table subaddress counter
    logic [7:0]      cp_cnt_r;      // Protection subaddress counter
    logic [7:0]      tx_r, tx_nxt;  // Byte being sent
    logic            oe_n_r, oe_n_nxt; // SDA release
    logic            cp_tog_r;      // Write event toggle
    ddc_pkg::cp_wr_t cp_hold_r;     // Last protection write

    // Decoded per-edge actions
    logic            start_det;     // SDA fell while SCL high
    logic            stop_det;      // SDA rose while SCL high
    logic [7:0]      rx_byte;       // Completed received byte
    logic            byte_done;     // Eighth bit just taken
    logic            hit_edid;      // Address matches table
    logic            hit_cp;        // Address matches registers
    logic [7:0]      top_sel;       // Top of selected map
    logic [7:0]      rd_byte;       // Byte at selected counter
    logic            cnt_load;      // Load counter from subaddress
    logic            cnt_step;      // Step counter one place
    logic            cp_we;         // Store byte to registers

    // System domain
    logic            cp_evt;        // Write event on system clock

    assign start_det = sda_pos_r & ~PORT_A_DDC_SERIAL_DATA_IN;
    assign stop_det  = ~sda_pos_r & PORT_A_DDC_SERIAL_DATA_IN;
    assign rx_byte   = {shift_r, sda_pos_r};
    assign byte_done = (bit_cnt_r == ddc_pkg::LAST_BIT);
    assign hit_edid  = rx_byte[7:1] == ddc_pkg::EDID_BUS_ADDR[7:1];
    assign hit_cp    = rx_byte[7:1] == ddc_pkg::CP_BUS_ADDR[7:1];
    assign top_sel   = sel_cp_r ? CP_TOP : EDID_TOP;
    assign rd_byte   = sel_cp_r ? cp_mem[cp_cnt_r]
                                : display_identification_table[edid_cnt_r];

    // Open drain: only ever pull low
    assign PORT_A_DDC_SERIAL_DATA_OUT  = 1'b0;
    assign PORT_A_DDC_SERIAL_DATA_OE_N = oe_n_r | ~link_rst_n;

    // Reset carried into the link domain
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        rst_meta_r <= RESET_N;
        link_rst_n <= rst_meta_r;
    end

    // Data bit captured while SCL high
    always_ff @(posedge PORT_A_DDC_SERIAL_CLOCK) begin
        sda_pos_r <= PORT_A_DDC_SERIAL_DATA_IN;
    end

    // Next phase and actions for this falling edge
    always_comb begin
        state_nxt = state_r;
        tx_nxt    = tx_r;
        oe_n_nxt  = oe_n_r;
        cnt_load  = 1'b0;
        cnt_step  = 1'b0;
        cp_we     = 1'b0;
        case (state_r)
            ddc_pkg::ST_ADDR: begin
                if (byte_done) begin
                    if (hit_edid || hit_cp) begin
                        state_nxt = ddc_pkg::ST_ADDR_ACK;
                        oe_n_nxt  = 1'b0;
                    end else begin
                        // Not ours: stay off the bus
                        state_nxt = ddc_pkg::ST_IDLE;
                    end
                end
            end
            ddc_pkg::ST_ADDR_ACK: begin
                if (rw_r) begin
                    // Read straight from the counter
                    state_nxt = ddc_pkg::ST_SEND;
                    tx_nxt    = rd_byte;
                    oe_n_nxt  = rd_byte[7];
                end else begin
                    state_nxt = ddc_pkg::ST_SUB;
                    oe_n_nxt  = 1'b1;
                end
            end
            ddc_pkg::ST_SUB: begin
                if (byte_done) begin
                    if (rx_byte > top_sel) begin
                        // Bad subaddress: no acknowledge
                        state_nxt = ddc_pkg::ST_IDLE;
                    end else begin
                        state_nxt = ddc_pkg::ST_SUB_ACK;
                        oe_n_nxt  = 1'b0;
                        cnt_load  = 1'b1;
                    end
                end
            end
            ddc_pkg::ST_SUB_ACK, ddc_pkg::ST_WACK: begin
                state_nxt = ddc_pkg::ST_WDATA;
                oe_n_nxt  = 1'b1;
            end
            ddc_pkg::ST_WDATA: begin
                if (byte_done) begin
                    if (over_r) begin
                        // Past top: byte dropped, no acknowledge
                        state_nxt = ddc_pkg::ST_IDLE;
                    end else begin
                        state_nxt = ddc_pkg::ST_WACK;
                        oe_n_nxt  = 1'b0;
                        cnt_step  = 1'b1;
                        cp_we     = sel_cp_r;
                    end
                end
            end
            ddc_pkg::ST_SEND: begin
                if (byte_done) begin
                    state_nxt = ddc_pkg::ST_MACK;
                    oe_n_nxt  = 1'b1;
                    cnt_step  = 1'b1;
                end else begin
                    tx_nxt   = {tx_r[6:0], 1'b1};
                    oe_n_nxt = tx_r[6];
                end
            end
            ddc_pkg::ST_MACK: begin
                if (!sda_pos_r) begin
                    // Master wants more
                    state_nxt = ddc_pkg::ST_SEND;
                    tx_nxt    = rd_byte;
                    oe_n_nxt  = rd_byte[7];
                end else begin
                    state_nxt = ddc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = ddc_pkg::ST_IDLE;
                oe_n_nxt  = 1'b1;
            end
        endcase
        // Start or stop anywhere overrides the phase
        if (start_det) begin
            state_nxt = ddc_pkg::ST_ADDR;
            oe_n_nxt  = 1'b1;
            cnt_load  = 1'b0;
            cnt_step  = 1'b0;
            cp_we     = 1'b0;
        end else if (stop_det) begin
            state_nxt = ddc_pkg::ST_IDLE;
            oe_n_nxt  = 1'b1;
            cnt_load  = 1'b0;
            cnt_step  = 1'b0;
            cp_we     = 1'b0;
        end
    end

    // Phase, bit counter and receive shifter
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        if (!link_rst_n) begin
            state_r   <= ddc_pkg::ST_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else begin
            state_r <= state_nxt;
            shift_r <= {shift_r[5:0], sda_pos_r};
            if (start_det) begin
                bit_cnt_r <= 3'h0;
            end else if (state_r == ddc_pkg::ST_ADDR ||
                         state_r == ddc_pkg::ST_SUB ||
                         state_r == ddc_pkg::ST_WDATA ||
                         state_r == ddc_pkg::ST_SEND) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end else begin
                bit_cnt_r <= 3'h0;
            end
        end
    end

    // Map select and direction from the address byte
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        if (!link_rst_n) begin
            sel_cp_r <= 1'b0;
            rw_r     <= 1'b0;
        end else if (state_r == ddc_pkg::ST_ADDR && byte_done) begin
            sel_cp_r <= hit_cp;
            rw_r     <= rx_byte[ddc_pkg::RW_BIT];
        end
    end

    // Subaddress counters, one per map, saturating at top
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        if (!link_rst_n) begin
            edid_cnt_r <= ddc_pkg::EDID_CNT_RESET;
            cp_cnt_r   <= ddc_pkg::CP_CNT_RESET;
            over_r     <= 1'b0;
        end else if (state_r == ddc_pkg::ST_ADDR && byte_done) begin
            over_r <= 1'b0;
        end else if (cnt_load) begin
            over_r <= 1'b0;
            if (sel_cp_r) begin
                cp_cnt_r <= rx_byte;
            end else begin
                edid_cnt_r <= rx_byte;
            end
        end else if (cnt_step) begin
            if (sel_cp_r) begin
                if (cp_cnt_r == CP_TOP) begin
                    over_r <= 1'b1;
                end else begin
                    cp_cnt_r <= cp_cnt_r + 8'h01;
                end
            end else begin
                if (edid_cnt_r == EDID_TOP) begin
                    over_r <= 1'b1;
                end else begin
                    edid_cnt_r <= edid_cnt_r + 8'h01;
                end
            end
        end
    end

    // SDA drive and transmit byte
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        if (!link_rst_n) begin
            oe_n_r <= 1'b1;
            tx_r   <= 8'hff;
        end else begin
            oe_n_r <= oe_n_nxt;
            tx_r   <= tx_nxt;
        end
    end

    // Protection register store and event toggle
    always_ff @(negedge PORT_A_DDC_SERIAL_CLOCK) begin
        if (!link_rst_n) begin
            cp_tog_r  <= 1'b0;
            cp_hold_r <= '0;
        end else if (cp_we) begin
            cp_mem[cp_cnt_r] <= rx_byte;
            cp_hold_r        <= '{addr: cp_cnt_r, data: rx_byte};
            cp_tog_r         <= ~cp_tog_r;
        end
    end

    // Table loaded by the system side only
    always_ff @(posedge CLK) begin
        if (TABLE_WR_EN) begin
            display_identification_table[TABLE_WR_ADDR] <= TABLE_WR_DATA;
        end
    end

    // Write event into system clock
    ddc_event_sync u_cp_sync (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .toggle_in (cp_tog_r),
        .pulse_out (cp_evt)
    );

    // Report writes and serve register reads on system clock
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CP_WR_STROBE <= 1'b0;
            CP_WR        <= '0;
            CP_RD_DATA   <= 8'h00;
        end else begin
            CP_WR_STROBE <= cp_evt;
            CP_RD_DATA   <= cp_mem[CP_RD_ADDR];
            if (cp_evt) begin
                CP_WR <= cp_hold_r; // Held stable long before the event
            end
        end
    end

    property p_ack_edid;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_ADDR && byte_done && hit_edid && !start_det
        && !stop_det |=> state_r == ddc_pkg::ST_ADDR_ACK && !oe_n_r;
    endproperty
    a_ack_edid: assert property (p_ack_edid)
        else $error("table address not acknowledged");

    property p_ack_cp;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_ADDR && byte_done && hit_cp && !start_det
        && !stop_det |=> !oe_n_r ##1 oe_n_r || state_r == ddc_pkg::ST_SEND;
    endproperty
    a_ack_cp: assert property (p_ack_cp)
        else $error("register address not acknowledged");

    property p_foreign;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_ADDR && byte_done && !hit_cp && !hit_edid
        && !start_det |=> state_r == ddc_pkg::ST_IDLE && oe_n_r;
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign address answered");

    property p_cur_read;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_ADDR_ACK && rw_r && !start_det && !stop_det
        |=> state_r == ddc_pkg::ST_SEND && tx_r == $past(rd_byte);
    endproperty
    a_cur_read: assert property (p_cur_read)
        else $error("current read not from counter");

    property p_step;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        cnt_step && !sel_cp_r && edid_cnt_r != EDID_TOP
        |=> edid_cnt_r == $past(edid_cnt_r) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("table counter did not step by one");

    property p_bad_sub;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_SUB && byte_done && rx_byte > top_sel
        && !start_det |=> state_r == ddc_pkg::ST_IDLE && oe_n_r;
    endproperty
    a_bad_sub: assert property (p_bad_sub)
        else $error("invalid subaddress acknowledged");

    property p_top_hold;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        cnt_step && sel_cp_r && cp_cnt_r == CP_TOP
        |=> cp_cnt_r == CP_TOP && over_r;
    endproperty
    a_top_hold: assert property (p_top_hold)
        else $error("counter left top register");

    property p_start;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        start_det |=> state_r == ddc_pkg::ST_ADDR && oe_n_r
        && bit_cnt_r == 3'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not restart transfer");

    property p_table_ro;
        @(negedge PORT_A_DDC_SERIAL_CLOCK) disable iff (!link_rst_n)
        state_r == ddc_pkg::ST_WDATA && byte_done && !sel_cp_r
        |-> !cp_we;
    endproperty
    a_table_ro: assert property (p_table_ro)
        else $error("table write reached register store");

endmodule // ddc_edid_cp_slave_port

`default_nettype wire

/* File: ddc_pkg.sv */
// Purpose: Shared constants and types for the display data port slave
// Assumes: 8-bit bus addresses include the direction bit position
// Notes:   Table and register sizes are set by the top module parameters
`default_nettype none

package ddc_pkg;

    // Bus addresses, direction bit in bit 0
    localparam logic [7:0] EDID_BUS_ADDR  = 8'ha0;
    localparam logic [7:0] CP_BUS_ADDR    = 8'h74;

    // Highest valid subaddress of each map
    localparam logic [7:0] EDID_TOP_DEF   = 8'hff;
    localparam logic [7:0] CP_TOP_DEF     = 8'h9f;

    // Counter values after reset
    localparam logic [7:0] EDID_CNT_RESET = 8'h00;
    localparam logic [7:0] CP_CNT_RESET   = 8'h00;

    // Bit positions and byte counts
    localparam int         BYTE_W         = 8;
    localparam logic [2:0] LAST_BIT       = 3'h7;
    localparam int         RW_BIT         = 0;

    // Link state machine, Gray coded along the write path
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_SUB      = 4'h2,
        ST_SUB_ACK  = 4'h6,
        ST_WDATA    = 4'h7,
        ST_WACK     = 4'h5,
        ST_SEND     = 4'h4,
        ST_MACK     = 4'hc
    } link_state_t;

    // Content-protection write reported to the system side
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } cp_wr_t;

endpackage : ddc_pkg

`default_nettype wire

/* File: ddc_event_sync.sv */
// Purpose: Carry a toggle event from the link clock into the system clock
// Assumes: Toggles are spaced far wider than three system clocks
// Notes:   Output is a one-cycle combinational pulse on the system clock
`default_nettype none

module ddc_event_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic toggle_in,
    output logic      pulse_out
);

    logic meta_r;   // First stage, read only by the second
    logic sync_r;   // Second stage
    logic last_r;   // Previous synchronised level

    // Two-flop synchroniser plus edge memory
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= toggle_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Any change of level is one event
    assign pulse_out = sync_r ^ last_r;

endmodule // ddc_event_sync

`default_nettype wire

/* File: ddc_host_model.sv */
// Purpose: Behavioural bus master for the display data port
// Assumes: 48 ns bit period; clock stands high between frames
// Notes:   Every acknowledge and every byte read is posted on obs_stb
`default_nettype none

module ddc_host_model (
    output logic       scl,      // Serial clock, high when idle
    output logic       sda_drv,  // Own data drive, 1 = released
    input  wire logic  sda,      // Resolved data wire
    output logic       obs_stb,  // Pulse: obs_val holds a result
    output logic [7:0] obs_val   // Byte read or acknowledge level
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam time QTR = 12ns; // Quarter of a bit period

    // Idle levels
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        obs_stb = 1'b0;
        obs_val = 8'h00;
    end

    // Free clocks with data released, only while the port is in reset
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            #1ns scl = 1'b0;
            #(2*QTR) scl = 1'b1;
            #(2*QTR - 1ns);
        end
    endtask

    // Hand one result to the bench
    task automatic report(input logic [7:0] v);
        obs_val = v;
        obs_stb = 1'b1;
        #1ns obs_stb = 1'b0;
    endtask

    // One pulse: data changed while low, sampled mid-high
    task automatic one_bit(input logic b, output logic r);
        sda_drv = b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // Data falls while the clock is high
    // Clock is pulled low first, so the port sees a rise with data high
    // before the fall; that first fall also lets it see a pending stop
    task automatic start();
        scl = 1'b0;
        sda_drv = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // Data rises while the clock is high, clock then stands
    // The port only acts on it at the next start's first falling edge
    task automatic stop();
        sda_drv = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_drv = 1'b1;
        #(2*QTR);
    endtask

    // Byte out MSB first, then the slave's acknowledge level
    task automatic wr_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) one_bit(b[i], r);
        one_bit(1'b1, r);
        report({7'h00, r});
    endtask

    // Byte in MSB first; the last byte is refused to end the read
    task automatic rd_byte(input logic last);
        logic [7:0] d;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, r);
            d[i] = r;
        end
        one_bit(last, r); // Released ninth bit ends the read
        report(d);
    endtask
endmodule // ddc_host_model

`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the display data port slave
// Assumes: Master model makes the link clock only within frames and in reset
// Notes:   Drivers queue expected results, monitors compare them
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] TBL = ddc_pkg::EDID_BUS_ADDR; // Table map
    localparam logic [7:0] CPA = ddc_pkg::CP_BUS_ADDR;   // Protection map
    localparam logic [7:0] ACK = 8'h00;   // Wire pulled low
    localparam logic [7:0] NAK = 8'h01;   // Wire left high
    localparam int         LIMIT = 6000;  // Cycle ceiling, ~4x the run

    logic            clk, reset_n, tbl_wr_en;     // System side inputs
    logic [7:0]      tbl_wr_addr, tbl_wr_data;    // Table loading
    logic [7:0]      cp_rd_addr, cp_rd_data;      // Register peek
    logic            cp_wr_strobe;                // Register write seen
    ddc_pkg::cp_wr_t cp_wr;                       // Its address and data
    logic            scl, sda_m, oe_n, dout;      // Bus pieces
    logic            obs_stb;                     // Master result pulse
    logic [7:0]      obs_val;                     // Master result
    wire             sda;                         // Open-drain wire
    logic [7:0]      exp_q[$];                    // Expected bus results
    logic [15:0]     cp_q[$];                     // Expected writes
    logic [7:0]      tbl[256];                    // Table copy
    logic [31:0]     seed;                        // Random state
    int              tests_run, miscompares, cycles;

    // Pull-up, master and slave all pulling down
    assign sda = sda_m & (oe_n ? 1'b1 : dout);

    ddc_edid_cp_slave_port DUT (
        .CLK                         (clk),
        .RESET_N                     (reset_n),
        .PORT_A_DDC_SERIAL_CLOCK     (scl),
        .PORT_A_DDC_SERIAL_DATA_IN   (sda),
        .PORT_A_DDC_SERIAL_DATA_OUT  (dout),
        .PORT_A_DDC_SERIAL_DATA_OE_N (oe_n),
        .TABLE_WR_EN                 (tbl_wr_en),
        .TABLE_WR_ADDR               (tbl_wr_addr),
        .TABLE_WR_DATA               (tbl_wr_data),
        .CP_RD_ADDR                  (cp_rd_addr),
        .CP_RD_DATA                  (cp_rd_data),
        .CP_WR_STROBE                (cp_wr_strobe),
        .CP_WR                       (cp_wr)
    );

    ddc_host_model host (
        .scl     (scl),
        .sda_drv (sda_m),
        .sda     (sda),
        .obs_stb (obs_stb),
        .obs_val (obs_val)
    );

    // 50 MHz system clock
    always #10 clk = ~clk;

    // Next random state
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Single comparison point
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Byte out with its expected acknowledge
    task automatic wr(input logic [7:0] b, input logic [7:0] a);
        exp_q.push_back(a);
        host.wr_byte(b);
    endtask

    // Byte in with its expected value
    task automatic rd(input logic [7:0] d, input logic last);
        exp_q.push_back(d);
        host.rd_byte(last);
    endtask

    // Start, map write, subaddress, repeated start, map read
    task automatic sub_rd(input logic [7:0] dev, input logic [7:0] sub);
        host.start();
        wr(dev, ACK);
        wr(sub, ACK);
        host.start();
        wr(dev | 8'h01, ACK);
    endtask

    // Bus result monitor
    always @(posedge obs_stb) begin
        check({8'h00, obs_val},
              {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : 8'hee});
    end

    // Register write monitor
    always @(posedge clk) begin
        if (cp_wr_strobe !== 1'b0)
            check(cp_wr, cp_q.size() > 0 ? cp_q.pop_front() : 16'heeee);
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        tbl_wr_en = 1'b0;
        tbl_wr_addr = 8'h00;
        tbl_wr_data = 8'h00;
        cp_rd_addr = 8'h00;
        seed = 32'h61d5;
        fork
            host.idle_clocks(5);
            begin
                repeat (6) @(posedge clk);
                reset_n <= 1'b1;
            end
        join
        // Fill the table with random bytes
        for (int i = 0; i < 256; i++) begin
            @(posedge clk);
            seed = lfsr(seed);
            tbl[i] = seed[7:0];
            tbl_wr_en <= 1'b1;
            tbl_wr_addr <= 8'(i);
            tbl_wr_data <= seed[7:0];
        end
        @(posedge clk);
        tbl_wr_en <= 1'b0;
        // Subaddressed table read, three bytes
        sub_rd(TBL, 8'h10);
        rd(tbl[8'h10], 1'b0);
        rd(tbl[8'h11], 1'b0);
        rd(tbl[8'h12], 1'b1);
        host.stop();
        // Current read continues after the last byte read
        host.start();
        wr(TBL | 8'h01, ACK);
        rd(tbl[8'h13], 1'b1);
        host.stop();
        // Table writes are acknowledged but only move the counter
        host.start();
        wr(TBL, ACK);
        wr(8'h20, ACK);
        wr(8'h55, ACK);
        wr(8'h66, ACK);
        host.stop();
        host.start();
        wr(TBL | 8'h01, ACK);
        rd(tbl[8'h22], 1'b1);
        host.stop();
        sub_rd(TBL, 8'h20);
        rd(tbl[8'h20], 1'b1);
        host.stop();
        // Foreign address, then a repeated start into a current read
        host.start();
        wr(8'h00, NAK);
        host.start();
        wr(TBL | 8'h01, ACK);
        rd(tbl[8'h21], 1'b1);
        host.stop();
        // Register writes, read back, then a short read
        cp_q.push_back(16'h105a);
        cp_q.push_back(16'h11a5);
        cp_q.push_back(16'h123c);
        host.start();
        wr(CPA, ACK);
        wr(8'h10, ACK);
        wr(8'h5a, ACK);
        wr(8'ha5, ACK);
        wr(8'h3c, ACK);
        host.stop();
        sub_rd(CPA, 8'h10);
        rd(8'h5a, 1'b0);
        rd(8'ha5, 1'b1);
        host.stop();
        host.start();
        wr(CPA | 8'h01, ACK);
        rd(8'h3c, 1'b1);
        host.stop();
        // System-side peek of each register written above
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            cp_rd_addr <= 8'h10 + 8'(k);
            repeat (2) @(posedge clk);
            #1 check(cp_rd_data, k == 0 ? 8'h5a : k == 1 ? 8'ha5 : 8'h3c);
        end
        // Top of the register map: write refused, read repeats top
        cp_q.push_back(16'h9e11);
        cp_q.push_back(16'h9f22);
        host.start();
        wr(CPA, ACK);
        wr(8'h9e, ACK);
        wr(8'h11, ACK);
        wr(8'h22, ACK);
        wr(8'h33, NAK);
        host.stop();
        sub_rd(CPA, 8'h9e);
        rd(8'h11, 1'b0);
        rd(8'h22, 1'b0);
        rd(8'h22, 1'b1);
        host.stop();
        // Invalid subaddress and a foreign bus address
        host.start();
        wr(CPA, ACK);
        wr(8'ha0, NAK);
        host.stop();
        host.start();
        wr(8'h50, NAK);
        host.stop();
        repeat (20) @(posedge clk);
        check(16'(cp_q.size()), 16'h0000);
        check(16'(exp_q.size()), 16'h0000);
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
